// ---- bench/host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_model
  import chg_cfg_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire reg_req_t cmd_i,
  output var reg_req_t req_o
);
  // Launched on the edge, so the register block samples it one cycle later
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      req_o <= '0;
    end else if (cmd_i.addr == OVP_REG_ADDR) begin
      req_o <= {cmd_i.wr_en, cmd_i.addr, cmd_i.wdata & OVP_WRITE_MASK};
    end else begin
      req_o <= cmd_i;
    end
  end
endmodule // host_model
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module testbench
  import chg_cfg_pkg::*;
;
  logic clk_sys_i, rstn_i, done, found;
  reg_req_t cmd, req;
  chg_status_t st;
  logic [7:0] rdata, d, w;
  logic [2:0] thr, t;
  logic [13:0] mv;
  logic half, swoff, mon, cold, dpon, det, production_test_mode, mode, ilim, bat;
  int n_mismatch, samples_checked, n_det, n_ptm, b_det, b_ptm;
  logic [31:0] seed, v;
  logic [13:0] mvt [8] = '{14'd6000, 14'd6500, 14'd7000, 14'd8000,
                           14'd9000, 14'd9500, 14'd10000, 14'd10500};

  host_model host (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .cmd_i(cmd), .req_o(req));

  charger_safety_test_config_regs dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .req_i(req),
    .status_i(st), .detect_done_i(done), .detect_found_i(found), .rdata_o(rdata),
    .timer_half_rate_o(half), .battery_switch_off_o(swoff), .thermistor_monitor_en_o(mon),
    .charge_suspend_cold_o(cold), .input_overvoltage_threshold_o(thr), .ovp_trip_mv_o(mv),
    .dplus_source_on_o(dpon), .battery_detect_start_o(det), .production_test_start_o(production_test_mode),
    .production_test_mode_o(mode), .input_current_limit_off_o(ilim),
    .battery_present_o(bat));

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  // High cycles counted, so a stretched pulse shows as an extra count
  always @(posedge clk_sys_i) begin
    n_det += (det === 1'b1);
    n_ptm += (production_test_mode === 1'b1);
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    cmd = {1'b1, a, x};
    @(posedge clk_sys_i) #1;
    cmd.wr_en = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] x);
    cmd = {1'b0, a, 8'h00};
    repeat (2) @(posedge clk_sys_i);
    #1 x = rdata;
  endtask

  task automatic print_verdict;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys_i);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    seed = 32'h5e162a77;
    cmd = '0;
    st = '0;
    done = 1'b0;
    found = 1'b0;
    rstn_i = 1'b0;
    repeat (16) @(posedge clk_sys_i);
    #1 rstn_i = 1'b1;
    rd(8'h06, d); `CHK("ovp_reset", 8'he0, d)
    rd(8'h05, d); `CHK("tmr_reset", 8'h88, d)
    rd(8'h33, d); `CHK("unmapped", 8'h00, d)
    for (int i = 0; i < 16; i++) begin
      v = $random(seed);
      st = v[15:8];
      if (i == 5) st.therm_code = 3'h4;
      // Cold is only meaningful with monitoring on
      if (st.therm_code == 3'h4) v[3] = 1'b1;
      w = {i[2:0], v[20], 4'h0};
      wr(8'h06, w);
      wr(8'h05, v[7:0]);
      rd(8'h06, d); `CHK("ovp_reg", w, d)
      `CHK("ovp_code", i[2:0], thr)
      `CHK("ovp_mv", mvt[i[2:0]], mv)
      `CHK("dplus_on", st.dplus_held & ~v[20], dpon)
      rd(8'h05, d);
      t = v[3] ? st.therm_code : 3'h7;
      `CHK("tmr_reg", {v[7], 2'h0, v[4:3], t}, d)
      `CHK("half_rate", v[7] & st.current_reduced, half)
      `CHK("sw_off", v[4] & ~st.input_present, swoff)
      `CHK("therm_en", v[3], mon)
      `CHK("cold", st.therm_code == 3'h4, cold)
    end
    st = '0;
    wr(8'h06, 8'h04);
    `CHK("ptm_on", 2'h3, {mode, ilim})
    `CHK("cold_clear", 1'b0, cold)
    wr(8'h06, 8'h00);
    `CHK("ptm_off", 1'b0, mode)
    st.battery_present = 1'b1;
    wr(8'h06, 8'h04);
    `CHK("ptm_refused", 1'b0, mode)
    wr(8'h06, 8'h00);
    st = '0;
    // Random termination in the loop also starts detection, so count from here
    b_det = n_det;
    b_ptm = n_ptm;
    wr(8'h06, 8'h08);
    `CHK("det_forced", 1, n_det - b_det)
    wr(8'h06, 8'h00);
    st.charge_terminated = 1'b1;
    wr(8'h06, 8'h04);
    `CHK("det_term", 2, n_det - b_det)
    wr(8'h06, 8'h00);
    st = '0;
    wr(8'h06, 8'h04);
    `CHK("det_ptm", 3, n_det - b_det)
    `CHK("ptm_pulses", 2, n_ptm - b_ptm)
    wr(8'h06, 8'h00);
    found = 1'b1;
    done = 1'b1;
    @(posedge clk_sys_i) #1;
    done = 1'b0;
    found = 1'b0;
    @(posedge clk_sys_i) #1;
    `CHK("bat_found", 1'b1, bat)
    wr(8'h06, 8'h04);
    `CHK("ptm_found_bat", 1'b0, mode)
    print_verdict();
  end
endmodule // testbench
`default_nettype wire

// ---- hw/charger_safety_test_config_regs.sv ----
// Contract
// - Doubling on: slow timer while current reduced
// - Doubling off: timer always normal rate
// - Disconnect on: input loss opens battery switch
// - Thermistor enable zero disables monitoring
// - Code 100 when cold, charging suspended
// - Register at 06, resets to e0
// - Three top bits select overvoltage trip
// - Bit four zero keeps D+ source
// - Writing one removes D+ 0.6V
// - Bit three forces detection, else conditional
// - Detection reports battery presence
// - Bit two enters production test mode
// - Refuse test mode with battery present
// - Doubling enable top bit, default one
// - Thermistor status low three bits, read-only
// - Disconnect bit four, thermistor enable bit three
`timescale 1ns/1ps
`default_nettype none
module charger_safety_test_config_regs
  import chg_cfg_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire reg_req_t req_i,
  input wire chg_status_t status_i,
  input wire logic detect_done_i,
  input wire logic detect_found_i,
  output logic [7:0] rdata_o,
  output logic timer_half_rate_o,
  output logic battery_switch_off_o,
  output logic thermistor_monitor_en_o,
  output logic charge_suspend_cold_o,
  output logic [2:0] input_overvoltage_threshold_o,
  output logic [13:0] ovp_trip_mv_o,
  output logic dplus_source_on_o,
  output logic battery_detect_start_o,
  output logic production_test_start_o,
  output logic production_test_mode_o,
  output logic input_current_limit_off_o,
  output logic battery_present_o
);
  typedef struct packed {
    logic timer_double_enable;
    logic battery_disconnect_on_input_loss;
    logic thermistor_sense_enable;
    logic [7:0] ovp_reg;
    logic [2:0] therm_stat;
    ptm_state_t production_test_mode;
    logic bat_seen;
    logic [7:0] rdata;
  } cfg_state_t;

  cfg_state_t st_ff;
  cfg_state_t nxt_st;
  logic detect_level;
  logic detect_pulse;
  logic ptm_pulse;

  function automatic logic hit(input reg_req_t r, input logic [7:0] a);
    return r.wr_en && (r.addr == a);
  endfunction

  // Unforced detection still starts on termination or on a test request
  assign detect_level = st_ff.ovp_reg[OVP_BATDET_BIT] | status_i.charge_terminated |
    st_ff.ovp_reg[OVP_PTM_BIT];

  req_pulse u_detect_pulse (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .level_i(detect_level),
    .pulse_o(detect_pulse)
  );

  req_pulse u_ptm_pulse (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .level_i(st_ff.ovp_reg[OVP_PTM_BIT]),
    .pulse_o(ptm_pulse)
  );

  always_comb begin
    nxt_st = st_ff;
    if (hit(req_i, TMR_REG_ADDR)) begin
      nxt_st.timer_double_enable = req_i.wdata[TMR_DOUBLE_BIT];
      nxt_st.battery_disconnect_on_input_loss = req_i.wdata[TMR_DISCONNECT_BIT];
      nxt_st.thermistor_sense_enable = req_i.wdata[TMR_THERM_EN_BIT];
    end else if (hit(req_i, OVP_REG_ADDR)) begin
      // Unused low bits held at zero even if host misbehaves
      nxt_st.ovp_reg = req_i.wdata & OVP_WRITE_MASK;
    end
    // Status is read-only, tracks the sensor unless disabled
    nxt_st.therm_stat = st_ff.thermistor_sense_enable ? status_i.therm_code
                                                      : THERM_OPEN;
    if (detect_done_i) begin
      nxt_st.bat_seen = detect_found_i;
    end
    case (st_ff.production_test_mode)
      PTM_IDLE: begin
        if (ptm_pulse) begin
          if (status_i.battery_present || st_ff.bat_seen) begin
            nxt_st.production_test_mode = PTM_REFUSED;
          end else begin
            nxt_st.production_test_mode = PTM_ACTIVE;
          end
        end
      end
      PTM_ACTIVE, PTM_REFUSED: begin
        if (!st_ff.ovp_reg[OVP_PTM_BIT]) begin
          nxt_st.production_test_mode = PTM_IDLE;
        end
      end
      default: nxt_st.production_test_mode = PTM_IDLE;
    endcase
    if (req_i.addr == TMR_REG_ADDR) begin
      nxt_st.rdata = {st_ff.timer_double_enable, 2'h0,
                      st_ff.battery_disconnect_on_input_loss,
                      st_ff.thermistor_sense_enable, st_ff.therm_stat};
    end else if (req_i.addr == OVP_REG_ADDR) begin
      nxt_st.rdata = st_ff.ovp_reg;
    end else begin
      nxt_st.rdata = 8'h00;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      st_ff.timer_double_enable <= TIMER_DOUBLE_RESET;
      st_ff.battery_disconnect_on_input_loss <= DISCONNECT_RESET;
      st_ff.thermistor_sense_enable <= THERM_ENABLE_RESET;
      st_ff.ovp_reg <= OVP_REG_RESET;
      st_ff.therm_stat <= THERM_NORMAL;
      st_ff.production_test_mode <= PTM_IDLE;
      st_ff.bat_seen <= 1'b0;
      st_ff.rdata <= 8'h00;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_o = st_ff.rdata;
  assign timer_half_rate_o = st_ff.timer_double_enable & status_i.current_reduced;
  assign battery_switch_off_o = st_ff.battery_disconnect_on_input_loss &
                                ~status_i.input_present;
  assign thermistor_monitor_en_o = st_ff.thermistor_sense_enable;
  // Suspended only while the registered status reads cold; clears once it leaves code 100
  assign charge_suspend_cold_o = (st_ff.therm_stat == THERM_COLD);
  assign input_overvoltage_threshold_o = st_ff.ovp_reg[OVP_THRESH_LSB +: 3];
  assign ovp_trip_mv_o = OVP_MV_TABLE[st_ff.ovp_reg[OVP_THRESH_LSB +: 3]];
  assign dplus_source_on_o = status_i.dplus_held &
                             ~st_ff.ovp_reg[OVP_RELEASE_BIT];
  assign battery_detect_start_o = detect_pulse;
  assign production_test_start_o = ptm_pulse & (st_ff.production_test_mode == PTM_IDLE) &
    ~(status_i.battery_present | st_ff.bat_seen);
  assign production_test_mode_o = (st_ff.production_test_mode == PTM_ACTIVE);
  assign input_current_limit_off_o = (st_ff.production_test_mode == PTM_ACTIVE);
  assign battery_present_o = st_ff.bat_seen;

  property p_reset_value;
    @(posedge clk_sys_i) $rose(rstn_i) |-> st_ff.ovp_reg == OVP_REG_RESET;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("ovp reset value wrong");

  property p_write_ovp;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      hit(req_i, OVP_REG_ADDR) |=> st_ff.ovp_reg == ($past(req_i.wdata) & OVP_WRITE_MASK);
  endproperty
  a_write_ovp: assert property (p_write_ovp) else $error("ovp write lost");

  property p_low_bits_zero;
    @(posedge clk_sys_i) disable iff (!rstn_i) st_ff.ovp_reg[1:0] == 2'h0;
  endproperty
  a_low_bits_zero: assert property (p_low_bits_zero) else $error("unused bits set");

  property p_half_rate;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (hit(req_i, TMR_REG_ADDR) && !req_i.wdata[TMR_DOUBLE_BIT]) |=> !timer_half_rate_o;
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("timer slowed wrongly");

  property p_cold;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (st_ff.thermistor_sense_enable && status_i.therm_code == THERM_COLD)
      |=> charge_suspend_cold_o;
  endproperty
  a_cold: assert property (p_cold) else $error("cold not suspended");

  property p_therm_off;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      !st_ff.thermistor_sense_enable |=> st_ff.therm_stat == THERM_OPEN;
  endproperty
  a_therm_off: assert property (p_therm_off) else $error("disabled status wrong");

  property p_refuse;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (ptm_pulse && status_i.battery_present) |=> !production_test_mode_o [*2];
  endproperty
  a_refuse: assert property (p_refuse) else $error("test mode with battery");

  property p_start_single;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      battery_detect_start_o |=> !battery_detect_start_o;
  endproperty
  a_start_single: assert property (p_start_single) else $error("detect not single");

  property p_release;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (hit(req_i, OVP_REG_ADDR) && req_i.wdata[OVP_RELEASE_BIT]) |=> !dplus_source_on_o;
  endproperty
  a_release: assert property (p_release) else $error("dplus not released");

  c_ptm: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) $rose(production_test_mode_o));
  c_refuse: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    st_ff.production_test_mode == PTM_REFUSED);
  c_detect: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) battery_detect_start_o);
  c_cold: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) charge_suspend_cold_o);
endmodule // charger_safety_test_config_regs
`default_nettype wire

// ---- hw/req_pulse.sv ----
`timescale 1ns/1ps
`default_nettype none
// Turns a level request bit into a one-cycle pulse on its rising edge
module req_pulse
  import chg_cfg_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic level_i,
  output logic pulse_o
);
  typedef struct packed {
    logic prev;
  } pulse_state_t;
  pulse_state_t st_ff;
  pulse_state_t nxt_st;

  always_comb begin
    nxt_st.prev = level_i;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pulse_o = level_i & ~st_ff.prev;
endmodule // req_pulse
`default_nettype wire

// ---- shared/chg_cfg_pkg.sv ----
package chg_cfg_pkg;
  // Register locations
  localparam logic [7:0] TMR_REG_ADDR = 8'h05;
  localparam logic [7:0] OVP_REG_ADDR = 8'h06;
  // Reset values
  localparam logic [7:0] OVP_REG_RESET = 8'he0;
  localparam logic [0:0] TIMER_DOUBLE_RESET = 1'h1;
  localparam logic [0:0] DISCONNECT_RESET = 1'h0;
  localparam logic [0:0] THERM_ENABLE_RESET = 1'h1;
  // Field positions, timer/thermistor register
  localparam int TMR_DOUBLE_BIT = 7;
  localparam int TMR_DISCONNECT_BIT = 4;
  localparam int TMR_THERM_EN_BIT = 3;
  localparam int TMR_STAT_LSB = 0;
  // Field positions, overvoltage/test register
  localparam int OVP_THRESH_LSB = 5;
  localparam int OVP_RELEASE_BIT = 4;
  localparam int OVP_BATDET_BIT = 3;
  localparam int OVP_PTM_BIT = 2;
  localparam logic [7:0] OVP_WRITE_MASK = 8'hfc;
  // Thermistor status codes
  localparam logic [2:0] THERM_NORMAL = 3'h0;
  localparam logic [2:0] THERM_COLD = 3'h4;
  localparam logic [2:0] THERM_OPEN = 3'h7;
  // Overvoltage codes, millivolts per code
  localparam logic [13:0] OVP_MV_TABLE [8] = '{14'd6000, 14'd6500, 14'd7000, 14'd8000,
                                               14'd9000, 14'd9500, 14'd10000, 14'd10500};

  typedef struct packed {
    logic       wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic current_reduced;
    logic input_present;
    logic battery_present;
    logic charge_terminated;
    logic dplus_held;
    logic [2:0] therm_code;
  } chg_status_t;

  typedef enum logic [1:0] {
    PTM_IDLE = 2'b00,
    PTM_ACTIVE = 2'b01,
    PTM_REFUSED = 2'b10
  } ptm_state_t;
endpackage
